// ### pkg/close_onto_fault_guard_pkg.sv
package close_onto_fault_guard_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] REL_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] TIME_OFS = 8'h0C;
   localparam logic [7:0] HIST_CNT_OFS = 8'h10;
   localparam logic [7:0] HIST_SEL_OFS = 8'h14;
   localparam logic [7:0] REC_EVT_OFS = 8'h18;
   localparam logic [7:0] REC_TIME_OFS = 8'h1C;
   localparam logic [7:0] REC_REM_OFS = 8'h20;
   localparam logic [7:0] REC_ACT_OFS = 8'h24;
   localparam logic [7:0] REL_GROUP_OFS = 8'h40;
   // ctrl fields
   localparam int MODE_LSB = 0;
   localparam int FORCE_EN_BIT = 4;
   localparam int FORCE_LSB = 5;
   localparam int STORE_ON_BIT = 8;
   localparam int STORE_OFF_BIT = 9;
   localparam int GROUP_LSB = 12;
   localparam logic [2:0] MODE_ON = 3'h1;
   localparam logic [2:0] MODE_BLOCKED = 3'h2;
   localparam logic [2:0] MODE_TEST = 3'h3;
   localparam logic [2:0] MODE_TEST_BLOCKED = 3'h4;
   localparam logic [2:0] MODE_OFF = 3'h5;
   localparam logic [1:0] FORCE_NORMAL = 2'h0;
   localparam logic [1:0] FORCE_BLOCKED = 2'h1;
   localparam logic [1:0] FORCE_ACTIVE = 2'h2;
   localparam logic [1:0] FORCE_TRIP = 2'h3;
   localparam logic [2:0] COND_NORMAL = 3'h0;
   localparam logic [2:0] COND_INIT = 3'h1;
   localparam logic [2:0] COND_ACTIVE = 3'h2;
   localparam logic [2:0] COND_TRIP = 3'h3;
   localparam logic [2:0] COND_BLOCKED = 3'h4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0301;
   // event codes: {signal, on}
   localparam logic [1:0] EV_INIT = 2'h0;
   localparam logic [1:0] EV_BLOCK = 2'h1;
   localparam logic [1:0] EV_ACTIVE = 2'h2;
   localparam logic [1:0] EV_TRIP = 2'h3;
   // timing: release time in ms, ms tick at 250 MHz
   localparam int CLK_MHZ = 250;
   localparam int MS_US = 1000;
   localparam int TICK_CYCLES = CLK_MHZ * MS_US;
   localparam logic [31:0] REL_DEFAULT_MS = 32'h0000_03E8;
   localparam logic [31:0] REL_MAX_MS = 32'h001B_7740;
   localparam int HIST_DEPTH = 12;
   localparam int GROUP_COUNT = 8;
endpackage

// ### hw/close_onto_fault_guard.sv
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// - rising edge on activate arms guard and starts release timing.
// - function input while armed trips at once.
// - armed for release time, default 1 s, max 1800 s.
// - block input held prevents the armed window from starting.
// - mode codes 1 On, 2 Blocked, 3 Test, 4 Test/Blocked, 5 Off; default On.
// - with forcing enabled, status forced Normal/Blocked/Active/Trip; default Normal.
// - condition code 0 Normal,1 Init,2 Active,3 Trip,4 Blocked.
// - separate blocked, active, trip outputs; each activation makes event and record.
// - on/off events for init, block, active, trip; storing on/off selectable.
// - events timestamped; last 12 records kept.
// - record holds time, event, setting group, remaining and elapsed time.
// - release time taken from the selected setting group.
module close_onto_fault_guard #(
   parameter int TICK = close_onto_fault_guard_pkg::TICK_CYCLES,
   parameter int DEPTH = close_onto_fault_guard_pkg::HIST_DEPTH
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic activate_in,
   input wire logic block_in,
   input wire logic function_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hsel_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic active_out,
   output logic trip_out,
   output logic blocked_out,
   output logic event_out,
   output logic [2:0] event_code_out
);
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_TRIPPED} state_e;
   state_e state_reg;
   logic [2:0] act_sync_reg, blk_sync_reg, fn_sync_reg;
   logic act_reg, blk_reg, fn_reg, act_prev_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] rel_group_reg [close_onto_fault_guard_pkg::GROUP_COUNT];
   logic [31:0] tick_cnt_reg, ms_time_reg, remain_reg, elapsed_reg;
   logic ap_wr_reg, ap_rd_reg;
   logic [7:0] ap_addr_reg;
   logic [3:0] hist_wr_reg, hist_cnt_reg, hist_sel_reg;
   logic [2:0] rec_evt [DEPTH];
   logic [31:0] rec_time [DEPTH];
   logic [31:0] rec_rem [DEPTH];
   logic [31:0] rec_act [DEPTH];
   logic [2:0] rec_group [DEPTH];
   logic [3:0] sig_prev_reg;
   logic [2:0] cond;
   logic [3:0] sig_now;
   logic [2:0] mode;
   logic [2:0] setting_group;
   logic [31:0] rel_ms;
   logic mode_block, mode_off, forcing, ms_tick, edge_act, do_trip;
   logic [3:0] rise, fall;
   logic store_ev;
   logic [2:0] ev_code;
   logic [3:0] rd_idx;

   // three-stage input synchronisers; levels filtered on stages two and three
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         act_sync_reg <= 3'h0;
         blk_sync_reg <= 3'h0;
         fn_sync_reg <= 3'h0;
      end else begin
         act_sync_reg <= {act_sync_reg[1:0], activate_in};
         blk_sync_reg <= {blk_sync_reg[1:0], block_in};
         fn_sync_reg <= {fn_sync_reg[1:0], function_in};
      end
   end

   // filtered levels change only when stages two and three agree
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         act_reg <= 1'b0;
         blk_reg <= 1'b0;
         fn_reg <= 1'b0;
         act_prev_reg <= 1'b0;
      end else begin
         if (act_sync_reg[1] == act_sync_reg[2]) act_reg <= act_sync_reg[2];
         if (blk_sync_reg[1] == blk_sync_reg[2]) blk_reg <= blk_sync_reg[2];
         if (fn_sync_reg[1] == fn_sync_reg[2]) fn_reg <= fn_sync_reg[2];
         act_prev_reg <= act_reg;
      end
   end

   assign mode = ctrl_reg[close_onto_fault_guard_pkg::MODE_LSB +: 3];
   assign setting_group = ctrl_reg[close_onto_fault_guard_pkg::GROUP_LSB +: 3];
   assign forcing = ctrl_reg[close_onto_fault_guard_pkg::FORCE_EN_BIT];
   // blocked and test/blocked modes act like a held block input
   assign mode_block = (mode == close_onto_fault_guard_pkg::MODE_BLOCKED) ||
                       (mode == close_onto_fault_guard_pkg::MODE_TEST_BLOCKED);
   assign mode_off = (mode == close_onto_fault_guard_pkg::MODE_OFF);
   assign rel_ms = rel_group_reg[setting_group];
   assign edge_act = act_reg && !act_prev_reg;
   assign ms_tick = (tick_cnt_reg == 32'(TICK - 1));
   assign do_trip = (state_reg == ST_ARMED) && fn_reg && !blk_reg && !mode_block;

   // millisecond timebase, also the event timestamp clock
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tick_cnt_reg <= 32'h0;
         ms_time_reg <= 32'h0;
      end else begin
         tick_cnt_reg <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;
         if (ms_tick) ms_time_reg <= ms_time_reg + 32'h1;
      end
   end

   // guard sequencing: arm, time the window, trip instantly
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= ST_IDLE;
         remain_reg <= 32'h0;
         elapsed_reg <= 32'h0;
      end else if (mode_off) begin
         state_reg <= ST_IDLE;
         remain_reg <= 32'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               // block wins over a coincident edge
               if (edge_act && !blk_reg && !mode_block) begin
                  state_reg <= ST_ARMED;
                  remain_reg <= (rel_ms == 32'h0) ? 32'h1 : rel_ms;
                  elapsed_reg <= 32'h0;
               end
            end
            ST_ARMED: begin
               if (do_trip) begin
                  state_reg <= ST_TRIPPED;
               end else if (blk_reg || mode_block) begin
                  state_reg <= ST_IDLE;
               end else if (ms_tick) begin
                  elapsed_reg <= elapsed_reg + 32'h1;
                  // the partial first ms is extra, so the window never falls short
                  if (remain_reg == 32'h0) begin
                     remain_reg <= 32'h0;
                     state_reg <= ST_IDLE;
                  end else begin
                     remain_reg <= remain_reg - 32'h1;
                  end
               end
            end
            ST_TRIPPED: begin
               // trip stands while the function input holds
               if (!fn_reg) state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // condition code, forced status overriding the live one
   always_comb begin
      cond = close_onto_fault_guard_pkg::COND_NORMAL;
      if (forcing) begin
         case (ctrl_reg[close_onto_fault_guard_pkg::FORCE_LSB +: 2])
            close_onto_fault_guard_pkg::FORCE_BLOCKED: cond = close_onto_fault_guard_pkg::COND_BLOCKED;
            close_onto_fault_guard_pkg::FORCE_ACTIVE: cond = close_onto_fault_guard_pkg::COND_ACTIVE;
            close_onto_fault_guard_pkg::FORCE_TRIP: cond = close_onto_fault_guard_pkg::COND_TRIP;
            default: cond = close_onto_fault_guard_pkg::COND_NORMAL;
         endcase
      end else if (state_reg == ST_TRIPPED) begin
         cond = close_onto_fault_guard_pkg::COND_TRIP;
      end else if (blk_reg || mode_block) begin
         cond = close_onto_fault_guard_pkg::COND_BLOCKED;
      end else if (state_reg == ST_ARMED) begin
         cond = (elapsed_reg == 32'h0) ? close_onto_fault_guard_pkg::COND_INIT : close_onto_fault_guard_pkg::COND_ACTIVE;
      end
   end

   // one-hot status indexed by event code: init, block, active, trip
   assign sig_now = {cond == close_onto_fault_guard_pkg::COND_TRIP, cond == close_onto_fault_guard_pkg::COND_ACTIVE,
                     cond == close_onto_fault_guard_pkg::COND_BLOCKED, cond == close_onto_fault_guard_pkg::COND_INIT};
   assign rise = sig_now & ~sig_prev_reg;
   assign fall = ~sig_now & sig_prev_reg;

   // pick one change per cycle, highest code first; lower ones follow later
   always_comb begin
      store_ev = 1'b0;
      ev_code = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (rise[i] && ctrl_reg[close_onto_fault_guard_pkg::STORE_ON_BIT]) begin
            store_ev = 1'b1;
            ev_code = {i[1:0], 1'b1};
         end else if (fall[i] && ctrl_reg[close_onto_fault_guard_pkg::STORE_OFF_BIT]) begin
            store_ev = 1'b1;
            ev_code = {i[1:0], 1'b0};
         end
      end
   end

   // outputs and event strobe straight from flops
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sig_prev_reg <= 4'h0;
         active_out <= 1'b0;
         trip_out <= 1'b0;
         blocked_out <= 1'b0;
         event_out <= 1'b0;
         event_code_out <= 3'h0;
      end else begin
         // of the stored changes only the reported one is retired, so none is lost
         for (int i = 0; i < 4; i++) begin
            if ((rise[i] || fall[i]) && (!store_ev || ev_code[2:1] == i[1:0] ||
                !ctrl_reg[rise[i] ? close_onto_fault_guard_pkg::STORE_ON_BIT : close_onto_fault_guard_pkg::STORE_OFF_BIT]))
               sig_prev_reg[i] <= sig_now[i];
         end
         active_out <= sig_now[close_onto_fault_guard_pkg::EV_ACTIVE] || sig_now[close_onto_fault_guard_pkg::EV_INIT];
         trip_out <= sig_now[close_onto_fault_guard_pkg::EV_TRIP];
         blocked_out <= sig_now[close_onto_fault_guard_pkg::EV_BLOCK];
         event_out <= store_ev;
         event_code_out <= ev_code;
      end
   end

   // record ring of the last entries, written on each stored event
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hist_wr_reg <= 4'h0;
         hist_cnt_reg <= 4'h0;
      end else if (store_ev) begin
         hist_wr_reg <= (hist_wr_reg == 4'(DEPTH - 1)) ? 4'h0 : hist_wr_reg + 4'h1;
         if (hist_cnt_reg != 4'(DEPTH)) hist_cnt_reg <= hist_cnt_reg + 4'h1;
      end
   end

   // record body: no reset needed, validity tracked by the count
   always_ff @(posedge clk_in) begin
      if (store_ev) begin
         rec_evt[hist_wr_reg] <= ev_code;
         rec_time[hist_wr_reg] <= ms_time_reg;
         rec_rem[hist_wr_reg] <= remain_reg;
         rec_act[hist_wr_reg] <= elapsed_reg;
         rec_group[hist_wr_reg] <= setting_group;
      end
   end

   // ahb-lite address phase capture; zero wait states
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ap_wr_reg <= 1'b0;
         ap_rd_reg <= 1'b0;
         ap_addr_reg <= 8'h0;
      end else if (hready_in) begin
         ap_wr_reg <= hsel_in && htrans_in[1] && hwrite_in;
         ap_rd_reg <= hsel_in && htrans_in[1] && !hwrite_in;
         ap_addr_reg <= haddr_in[7:0];
      end
   end

   // software writes in the data phase; release clamped to its maximum
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_reg <= close_onto_fault_guard_pkg::CTRL_RESET;
         hist_sel_reg <= 4'h0;
         for (int g = 0; g < close_onto_fault_guard_pkg::GROUP_COUNT; g++)
            rel_group_reg[g] <= close_onto_fault_guard_pkg::REL_DEFAULT_MS;
      end else if (ap_wr_reg) begin
         if (ap_addr_reg == close_onto_fault_guard_pkg::CTRL_OFS) ctrl_reg <= hwdata_in & 32'h0000_737F;
         if (ap_addr_reg == close_onto_fault_guard_pkg::REL_OFS)
            rel_group_reg[setting_group] <= (hwdata_in > close_onto_fault_guard_pkg::REL_MAX_MS) ?
                                            close_onto_fault_guard_pkg::REL_MAX_MS : hwdata_in;
         for (int g = 0; g < close_onto_fault_guard_pkg::GROUP_COUNT; g++) begin
            if (ap_addr_reg == close_onto_fault_guard_pkg::REL_GROUP_OFS + 8'(4 * g))
               rel_group_reg[g] <= (hwdata_in > close_onto_fault_guard_pkg::REL_MAX_MS) ? close_onto_fault_guard_pkg::REL_MAX_MS
                                                                      : hwdata_in;
         end
         if (ap_addr_reg == close_onto_fault_guard_pkg::HIST_SEL_OFS) hist_sel_reg <= hwdata_in[3:0];
      end
   end

   // history select 0 is the newest record
   assign rd_idx = (hist_wr_reg > hist_sel_reg) ? hist_wr_reg - hist_sel_reg - 4'h1
                                                : 4'(DEPTH) + hist_wr_reg - hist_sel_reg - 4'h1;

   // read data registered, so it stands in the cycle after the address phase
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hrdata_out <= 32'h0;
      end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
         case (haddr_in[7:0])
            close_onto_fault_guard_pkg::CTRL_OFS: hrdata_out <= ctrl_reg;
            close_onto_fault_guard_pkg::REL_OFS: hrdata_out <= rel_ms;
            close_onto_fault_guard_pkg::STATUS_OFS: hrdata_out <= {20'h0, 1'b0, mode, 1'b0, cond, 4'(state_reg)};
            close_onto_fault_guard_pkg::TIME_OFS: hrdata_out <= ms_time_reg;
            close_onto_fault_guard_pkg::HIST_CNT_OFS: hrdata_out <= {28'h0, hist_cnt_reg};
            close_onto_fault_guard_pkg::HIST_SEL_OFS: hrdata_out <= {28'h0, hist_sel_reg};
            close_onto_fault_guard_pkg::REC_EVT_OFS: hrdata_out <= {25'h0, rec_group[rd_idx], 1'b0, rec_evt[rd_idx]};
            close_onto_fault_guard_pkg::REC_TIME_OFS: hrdata_out <= rec_time[rd_idx];
            close_onto_fault_guard_pkg::REC_REM_OFS: hrdata_out <= rec_rem[rd_idx];
            close_onto_fault_guard_pkg::REC_ACT_OFS: hrdata_out <= rec_act[rd_idx];
            default: hrdata_out <= (haddr_in[7:5] == 3'h2) ? rel_group_reg[haddr_in[4:2]] : 32'h0;
         endcase
      end
   end

   // always ready, always okay
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end
endmodule

// ### bench/close_cmd_model.sv
`timescale 1ns/1ns
// far side: breaker close command logic and the protection stage starts
module close_cmd_model #(
   parameter int PULSE = 8
) (
   input wire logic clk_in,
   input wire logic close_req_in,
   input wire logic fault_req_in,
   input wire logic block_req_in,
   output logic activate_out,
   output logic function_out,
   output logic block_out
);
   logic [7:0] cnt_reg = 8'h00;
   // the close command is held for several cycles so the input filter sees it settle
   always_ff @(posedge clk_in) begin
      if (close_req_in) begin
         cnt_reg <= 8'(PULSE);
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end
   assign activate_out = (cnt_reg != 8'h00);
   // protection start and block are plain levels from other stages
   assign function_out = fault_req_in;
   assign block_out = block_req_in;
endmodule

// ### bench/guard_checker_sva.sv
`timescale 1ns/1ns
module guard_checker (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic activate_in,
   input wire logic block_in,
   input wire logic function_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hsel_in,
   input wire logic hready_in,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic active_out,
   input wire logic trip_out,
   input wire logic blocked_out,
   input wire logic event_out,
   input wire logic [2:0] event_code_out
);
   logic wr_ctrl_reg;
   logic force_reg;
   logic store_on_reg;
   logic [7:0] fn_hist_reg;
   logic [7:0] act_hist_reg;
   // track forcing and ON storage from bus writes; forced outputs have no input cause
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ctrl_reg <= 1'b0;
         force_reg <= 1'b0;
         store_on_reg <= 1'b1;
      end else if (hready_in) begin
         wr_ctrl_reg <= hsel_in && htrans_in[1] && hwrite_in && haddr_in[7:0] == 8'h00;
         if (wr_ctrl_reg) begin
            force_reg <= hwdata_in[4];
            store_on_reg <= hwdata_in[8];
         end
      end
   end
   // recent input history, wide enough to cover the input filter delay
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fn_hist_reg <= 8'h00;
         act_hist_reg <= 8'h00;
      end else begin
         fn_hist_reg <= {fn_hist_reg[6:0], function_in};
         act_hist_reg <= {act_hist_reg[6:0], activate_in};
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in || force_reg);
   sequence s_init_on;
      event_out && event_code_out == 3'h1;
   endsequence
   sequence s_trip_on;
      event_out && event_code_out == 3'h7;
   endsequence
   a_ready_always: assert property (hreadyout_out)
      else $error("slave inserted a wait state");
   a_okay_resp: assert property (!hresp_out)
      else $error("slave gave an error response");
   a_outputs_exclusive: assert property ($onehot0({active_out, trip_out, blocked_out}))
      else $error("more than one status output high");
   a_arm_cause: assert property ($rose(active_out) |-> (|act_hist_reg))
      else $error("guard armed without activate input");
   a_trip_cause: assert property ($rose(trip_out) |-> $past(active_out) && (|fn_hist_reg))
      else $error("trip without armed guard and function input");
   a_trip_holds: assert property (trip_out && (&fn_hist_reg) && !block_in |=> trip_out)
      else $error("trip dropped while function input held");
   a_init_event: assert property (disable iff (!arst_n_in || force_reg || !store_on_reg)
      $rose(active_out) |-> ##[0:8] s_init_on)
      else $error("no init on event after arming");
   a_trip_event: assert property (disable iff (!arst_n_in || force_reg || !store_on_reg)
      $rose(trip_out) |-> ##[0:8] s_trip_on)
      else $error("no trip on event after trip");
endmodule
bind close_onto_fault_guard guard_checker chk_i (.clk_in, .arst_n_in, .activate_in, .block_in,
   .function_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hsel_in, .hready_in,
   .hreadyout_out, .hresp_out, .active_out, .trip_out, .blocked_out, .event_out, .event_code_out);

// ### bench/tb.sv
`timescale 1ns/1ns
module tb;
   localparam int TK = 16;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic close_req = 1'b0;
   logic fault_req = 1'b0;
   logic block_req = 1'b0;
   logic activate, func, blk, hready, hresp, active, trip, blocked, evt, s, on;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] hrdata, q;
   logic [2:0] evt_code;
   int failures = 0;
   int comparisons = 0;
   int n, e;
   always #2 clk_in = ~clk_in;
   close_onto_fault_guard #(.TICK(TK)) DUT (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .activate_in(activate), .block_in(blk), .function_in(func), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hsel_in(hsel), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .active_out(active), .trip_out(trip), .blocked_out(blocked),
      .event_out(evt), .event_code_out(evt_code));
   close_cmd_model far (.clk_in(clk_in), .close_req_in(close_req), .fault_req_in(fault_req),
      .block_req_in(block_req), .activate_out(activate), .function_out(func),
      .block_out(blk));
   task finish_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // one edge at a time until the slave shows ready; hangs are cut off
   task ready_wait;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk(0, 1, "bus timeout");
         finish_test();
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      ready_wait();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      ready_wait();
      q = hrdata;
   endtask
   task wait_lvl(input logic is_trip, input logic lvl, input int lim);
      n = 0;
      while ((is_trip ? trip : active) !== lvl && n < lim) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      if (n >= lim) begin
         chk(0, 1, "output wait timeout");
         finish_test();
      end
   endtask
   task arm;
      @(posedge clk_in);
      close_req <= 1'b1;
      @(posedge clk_in);
      close_req <= 1'b0;
   endtask
   // arm, then watch for a full window: arming seen, events stored, any ON stored
   task run_arm;
      s = 1'b0;
      on = 1'b0;
      e = 0;
      arm();
      repeat (8 * TK) begin
         @(posedge clk_in);
         #1;
         s |= active;
         e += int'(evt === 1'b1);
         on |= evt & evt_code[0];
      end
   endtask
   task t_reset;
      bus(0, close_onto_fault_guard_pkg::CTRL_OFS, 0);
      chk(q, 32'h0000_0301, "ctrl reset");
      bus(0, close_onto_fault_guard_pkg::REL_OFS, 0);
      chk(q, 32'h0000_03E8, "release default");
      bus(0, 8'h3C, 0);
      chk(q, 32'h0, "unmapped read");
      bus(0, close_onto_fault_guard_pkg::STATUS_OFS, 0);
      chk(q[6:4], close_onto_fault_guard_pkg::COND_NORMAL, "condition idle");
      chk({trip, active, blocked}, 3'h0, "outputs idle");
      $display("reset test done");
   endtask
   task t_trip;
      bus(1, close_onto_fault_guard_pkg::REL_OFS, 32'h5);
      arm();
      wait_lvl(0, 1, 40);
      bus(0, close_onto_fault_guard_pkg::STATUS_OFS, 0);
      chk(q[6:4], close_onto_fault_guard_pkg::COND_INIT, "condition init");
      fault_req <= 1'b1;
      wait_lvl(1, 1, 16);
      chk(active, 1'b0, "active after trip");
      bus(0, close_onto_fault_guard_pkg::STATUS_OFS, 0);
      chk(q[6:4], close_onto_fault_guard_pkg::COND_TRIP, "condition trip");
      @(posedge clk_in) fault_req <= 1'b0;
      wait_lvl(1, 0, 16);
      bus(0, close_onto_fault_guard_pkg::HIST_CNT_OFS, 0);
      chk(q != 0 && q <= 12, 1, "record count");
      bus(0, close_onto_fault_guard_pkg::REC_EVT_OFS, 0);
      chk(q[2:0], {close_onto_fault_guard_pkg::EV_TRIP, 1'b0}, "newest record event");
      bus(0, close_onto_fault_guard_pkg::REC_REM_OFS, 0);
      chk(q, 32'h5, "record remaining time");
      bus(1, close_onto_fault_guard_pkg::HIST_SEL_OFS, 32'h1);
      bus(0, close_onto_fault_guard_pkg::REC_EVT_OFS, 0);
      chk(q[2:0], {close_onto_fault_guard_pkg::EV_INIT, 1'b0}, "older record event");
      $display("trip test done");
   endtask
   task t_window(input logic [31:0] ms);
      arm();
      wait_lvl(0, 1, 40);
      wait_lvl(0, 0, 8 * TK);
      chk(n >= ms * TK - 4 && n <= (ms + 1) * TK + 4, 1, "window length");
      bus(0, close_onto_fault_guard_pkg::STATUS_OFS, 0);
      chk(q[6:4], close_onto_fault_guard_pkg::COND_NORMAL, "condition after expiry");
      $display("window test done");
   endtask
   task t_block;
      block_req <= 1'b1;
      run_arm();
      chk(s, 1'b0, "armed while blocked");
      @(posedge clk_in) block_req <= 1'b0;
      $display("block test done");
   endtask
   task t_modes;
      for (int m = 1; m <= 5; m++) begin
         bus(1, close_onto_fault_guard_pkg::CTRL_OFS, 32'h300 | m);
         run_arm();
         chk(s, m == 1 || m == 3, "arming per mode");
      end
      for (int k = 0; k < 3; k++) begin
         bus(1, close_onto_fault_guard_pkg::CTRL_OFS, k == 0 ? 32'h001 : k == 1 ? 32'h201 : 32'h101);
         run_arm();
         chk({e != 0, on}, k == 0 ? 2'h0 : k == 1 ? 2'h2 : 2'h3, "event storing");
      end
      $display("mode test done");
   endtask
   task t_force;
      for (int f = 0; f < 4; f++) begin
         bus(1, close_onto_fault_guard_pkg::CTRL_OFS, 32'h311 | (f << 5));
         repeat (8) @(posedge clk_in);
         chk({trip, active, blocked}, f == 0 ? 0 : 1 << (f - 1), "forced status");
      end
      bus(1, close_onto_fault_guard_pkg::CTRL_OFS, 32'h301);
      repeat (8) @(posedge clk_in);
      $display("force test done");
   endtask
   task t_group;
      bus(1, close_onto_fault_guard_pkg::REL_GROUP_OFS + 8'h08, 32'h2);
      bus(1, close_onto_fault_guard_pkg::CTRL_OFS, 32'h2301);
      bus(0, close_onto_fault_guard_pkg::REL_OFS, 0);
      chk(q, 32'h2, "group release");
      t_window(2);
      bus(1, close_onto_fault_guard_pkg::CTRL_OFS, 32'h301);
      $display("group test done");
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      arst_n_in <= 1'b1;
      t_reset();
      t_trip();
      t_window(5);
      t_block();
      t_modes();
      t_force();
      t_group();
      finish_test();
   end
endmodule
